// ### logic/uart_frame_format_and_status.sv
// top: apb register file, interrupt, transmit path and pin polarity
// assumes an apb master on mclk; serial pin goes straight to the pad
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_frame_format_and_status
   import uart_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             serialTxPin,
   output logic             irq
);
   ////////////////////////////////////////////////////////////////////////
   logic [15:0] serialModeConfig_reg, serialModeConfig_next;
   logic [15:0] serialStatusControl_reg, serialStatusControl_next;
   logic [15:0] baudDiv_reg, baudDiv_next;
   logic [8:0]  txData_reg, txData_next;
   logic        txPending_reg, txPending_next;
   logic [1:0]  irqStat_reg, irqStat_next;
   logic [1:0]  irqMask_reg, irqMask_next;
   logic [31:0] prdata_next;
   logic        pslverr_next, irq_next, serialTxPin_next;
   logic        accessWr, accessRd, bitTick, txLine, txBusy, breakDone, txLoad, busyDly_reg;
   frame_cfg_s  cfg;

   function automatic logic [15:0] mergeWr(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
      logic [15:0] be;
      be = {{8{s[1]}}, {8{s[0]}}} & m;
      mergeWr = (old & ~be) | (d[15:0] & be);
   endfunction : mergeWr

   assign accessWr = psel && penable && pwrite;
   assign accessRd = psel && penable && !pwrite;
   assign cfg      = '{infraredEncoderOn:   serialModeConfig_reg[`MODE_IR_BIT],
                       highSpeedBaudSelect: serialModeConfig_reg[`MODE_HSPEED_BIT],
                       parityDataSelect:    serialModeConfig_reg[`MODE_FMT_LSB+1:`MODE_FMT_LSB],
                       stopBitSelect:       serialModeConfig_reg[`MODE_STOP_BIT]};
   assign txLoad   = txPending_reg && !txBusy && !serialStatusControl_reg[`STAT_BRK_BIT];

   ////////////////////////////////////////////////////////////////////////
   uart_baud_gen u_baud (
      .mclk      (mclk),
      .resetn    (resetn),
      .divisor   (baudDiv_reg),
      .highSpeed (cfg.highSpeedBaudSelect),
      .bitTick   (bitTick)
   );

   uart_tx_shifter u_tx (
      .mclk      (mclk),
      .resetn    (resetn),
      .bitTick   (bitTick),
      .cfg       (cfg),
      .load      (txLoad),
      .loadData  (txData_reg),
      .breakReq  (serialStatusControl_reg[`STAT_BRK_BIT]),
      .txLine    (txLine),
      .busy      (txBusy),
      .breakDone (breakDone)
   );

   ////////////////////////////////////////////////////////////////////////
   // register writes; hardware clears and sets win over software
   always_comb begin
      serialModeConfig_next    = serialModeConfig_reg;
      serialStatusControl_next = serialStatusControl_reg;
      baudDiv_next             = baudDiv_reg;
      txData_next              = txData_reg;
      txPending_next           = txPending_reg;
      irqStat_next             = irqStat_reg;
      irqMask_next             = irqMask_reg;
      if (accessWr) begin
         case (paddr)
            `OFF_MODE: serialModeConfig_next = mergeWr(serialModeConfig_reg, pwdata, pstrb, `MODE_WMASK);
            `OFF_STAT: serialStatusControl_next =
               mergeWr(serialStatusControl_reg, pwdata, pstrb, `STAT_WMASK);
            `OFF_BAUD: baudDiv_next = mergeWr(baudDiv_reg, pwdata, pstrb, 16'hFFFF);
            `OFF_DATA: if (!txPending_reg && pstrb[0]) begin
               txData_next    = pwdata[8:0];
               txPending_next = 1'b1;
            end
            `OFF_IRQ_STAT: if (pstrb[0]) irqStat_next = irqStat_reg & ~pwdata[1:0];
            `OFF_IRQ_MASK: if (pstrb[0]) irqMask_next = pwdata[1:0];
            default: ;
         endcase
      end
      if (txLoad) txPending_next = 1'b0;
      if (breakDone) serialStatusControl_next[`STAT_BRK_BIT] = 1'b0;
      serialStatusControl_next[`STAT_BUSY_BIT] = txPending_next;
      serialStatusControl_next[`STAT_TRMT_BIT] = !txBusy && !txPending_reg;
      if (busyDly_reg && !txBusy) irqStat_next[0] = 1'b1;
      if (breakDone) irqStat_next[1] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      prdata_next  = 32'h0000_0000;
      pslverr_next = 1'b0;
      if (psel && !penable) begin
         case (paddr)
            `OFF_MODE:     prdata_next = {16'h0000, serialModeConfig_reg};
            `OFF_STAT:     prdata_next = {16'h0000, serialStatusControl_reg};
            `OFF_DATA:     prdata_next = {23'h00_0000, txData_reg};
            `OFF_BAUD:     prdata_next = {16'h0000, baudDiv_reg};
            `OFF_IRQ_STAT: prdata_next = {30'h0000_0000, irqStat_reg};
            `OFF_IRQ_MASK: prdata_next = {30'h0000_0000, irqMask_reg};
            default:       pslverr_next = 1'b1;
         endcase
      end else begin
         prdata_next  = prdata;
      end
      irq_next         = |(irqStat_next & irqMask_next);
      // inversion only reaches the pin with the infrared encoder on
      serialTxPin_next = txLine ^ (cfg.infraredEncoderOn & serialStatusControl_reg[`STAT_INV_BIT]);
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         serialModeConfig_reg    <= `MODE_RESET;
         serialStatusControl_reg <= `STAT_RESET;
         baudDiv_reg             <= `BAUD_RESET;
         txData_reg              <= 9'h000;
         txPending_reg           <= 1'b0;
         irqStat_reg             <= 2'b00;
         irqMask_reg             <= 2'b00;
         prdata                  <= 32'h0000_0000;
         pslverr                 <= 1'b0;
         pready                  <= 1'b0;
         irq                     <= 1'b0;
         serialTxPin             <= 1'b1;
         busyDly_reg             <= 1'b0;
      end else begin
         serialModeConfig_reg    <= serialModeConfig_next;
         serialStatusControl_reg <= serialStatusControl_next;
         baudDiv_reg             <= baudDiv_next;
         txData_reg              <= txData_next;
         txPending_reg           <= txPending_next;
         irqStat_reg             <= irqStat_next;
         irqMask_reg             <= irqMask_next;
         prdata                  <= prdata_next;
         pslverr                 <= pslverr_next;
         pready                  <= psel && !penable;
         irq                     <= irq_next;
         serialTxPin             <= serialTxPin_next;
         busyDly_reg             <= txBusy;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_BRK_CLEAR: assert property (@(posedge mclk) disable iff (!resetn)
      breakDone |=> !serialStatusControl_reg[`STAT_BRK_BIT])
      else $error("break request not cleared by hardware");
   AST_INV_GATED: assert property (@(posedge mclk) disable iff (!resetn)
      (!cfg.infraredEncoderOn && $stable(cfg.infraredEncoderOn)) |=> serialTxPin == $past(txLine))
      else $error("pin inverted without encoder on");
   AST_INV_ON: assert property (@(posedge mclk) disable iff (!resetn)
      (cfg.infraredEncoderOn && serialStatusControl_reg[`STAT_INV_BIT]) |=> serialTxPin != $past(txLine))
      else $error("pin not inverted");
   AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!resetn)
      irq == |(irqStat_reg & irqMask_reg))
      else $error("interrupt level mismatch");
endmodule : uart_frame_format_and_status

// ### logic/uart_cfg.svh
// constants for the serial port frame format and status block
// assumes an APB slave at mclk 125 MHz, word aligned registers
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define OFF_MODE        12'h000
`define OFF_STAT        12'h004
`define OFF_DATA        12'h008
`define OFF_BAUD        12'h00C
`define OFF_IRQ_STAT    12'h010
`define OFF_IRQ_MASK    12'h014
`define MODE_STOP_BIT   0
`define MODE_FMT_LSB    1
`define MODE_HSPEED_BIT 3
`define MODE_IR_BIT     12
`define STAT_TRMT_BIT   8
`define STAT_BUSY_BIT   9
`define STAT_BRK_BIT    11
`define STAT_INV_BIT    14
`define MODE_RESET      16'h0000
`define STAT_RESET      16'h0100
`define STAT_WMASK      16'h4800
`define MODE_WMASK      16'h100F
`define BAUD_RESET      16'h0000
`define TICKS_HIGH      5'h04
`define TICKS_STD       5'h10
`define BREAK_ZEROS     4'hC
`endif

// ### logic/uart_pkg.sv
// types for the serial port frame format and status block
// assumes uart_cfg.svh is included by the modules that need numbers
package uart_pkg;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_START  = 3'b001,
      ST_DATA   = 3'b011,
      ST_PARITY = 3'b010,
      ST_STOP   = 3'b110,
      ST_BREAK  = 3'b111
   } tx_state_e;
   typedef struct packed {
      logic       infraredEncoderOn;
      logic       highSpeedBaudSelect;
      logic [1:0] parityDataSelect;
      logic       stopBitSelect;
   } frame_cfg_s;
endpackage : uart_pkg

// ### logic/uart_baud_gen.sv
// baud tick generator with 4x or 16x oversampling
// assumes divisor comes from a register on the same clock
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_baud_gen
   import uart_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic [15:0] divisor,
   input  wire logic        highSpeed,
   output logic             bitTick
);
   logic [15:0] divCnt_reg, divCnt_next;
   logic [4:0]  subCnt_reg, subCnt_next;
   logic        bitTick_next;
   logic [4:0]  ticksPerBit;

   always_comb begin
      ticksPerBit  = highSpeed ? `TICKS_HIGH : `TICKS_STD;
      divCnt_next  = divCnt_reg + 16'h0001;
      subCnt_next  = subCnt_reg;
      bitTick_next = 1'b0;
      if (divCnt_reg >= divisor) begin
         divCnt_next = 16'h0000;
         if (subCnt_reg >= ticksPerBit - 5'h01) begin
            subCnt_next  = 5'h00;
            bitTick_next = 1'b1;
         end else begin
            subCnt_next = subCnt_reg + 5'h01;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         divCnt_reg <= 16'h0000;
         subCnt_reg <= 5'h00;
         bitTick    <= 1'b0;
      end else begin
         divCnt_reg <= divCnt_next;
         subCnt_reg <= subCnt_next;
         bitTick    <= bitTick_next;
      end
   end

   AST_TICK_SPACING: assert property (@(posedge mclk) disable iff (!resetn)
      (bitTick && highSpeed && divisor == 16'h0000) ##1 (highSpeed && divisor == 16'h0000) [*3]
      |=> (bitTick && !$past(bitTick) && !$past(bitTick, 2) && !$past(bitTick, 3)))
      else $error("high speed tick spacing wrong");
endmodule : uart_baud_gen

// ### logic/uart_tx_shifter.sv
// frame serialiser: start, data lsb first, parity, stops, break
// assumes bitTick pulses once per bit period
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_tx_shifter
   import uart_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       bitTick,
   input  frame_cfg_s      cfg,
   input  wire logic       load,
   input  wire logic [8:0] loadData,
   input  wire logic       breakReq,
   output logic            txLine,
   output logic            busy,
   output logic            breakDone
);
   tx_state_e   state_reg, state_next;
   logic [8:0]  shift_reg, shift_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic        par_reg, par_next;
   logic        txLine_next, breakDone_next;

   function automatic logic parityOf(input logic [7:0] d, input logic odd);
      parityOf = ^d ^ odd;
   endfunction : parityOf

   always_comb begin
      state_next     = state_reg;
      shift_next     = shift_reg;
      cnt_next       = cnt_reg;
      par_next       = par_reg;
      txLine_next    = txLine;
      breakDone_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            txLine_next = 1'b1;
            // request bit is cleared one cycle after breakDone; do not restart on it
            if (breakReq && !breakDone) begin
               state_next = ST_BREAK;
               cnt_next   = 4'h0;
            end else if (load) begin
               shift_next = loadData;
               par_next   = parityOf(loadData[7:0], cfg.parityDataSelect == 2'b10);
               state_next = ST_START;
            end
         end
         ST_START: if (bitTick) begin
            txLine_next = 1'b0;
            cnt_next    = 4'h0;
            state_next  = ST_DATA;
         end
         ST_DATA: if (bitTick) begin
            txLine_next = shift_reg[0];
            shift_next  = {1'b0, shift_reg[8:1]};
            cnt_next    = cnt_reg + 4'h1;
            if (cnt_reg == ((cfg.parityDataSelect == 2'b11) ? 4'h8 : 4'h7)) begin
               state_next = (cfg.parityDataSelect == 2'b01 || cfg.parityDataSelect == 2'b10) ?
                            ST_PARITY : ST_STOP;
               cnt_next   = 4'h0;
            end
         end
         ST_PARITY: if (bitTick) begin
            txLine_next = par_reg;
            state_next  = ST_STOP;
         end
         ST_STOP: if (bitTick) begin
            txLine_next = 1'b1;
            cnt_next    = cnt_reg + 4'h1;
            if (cnt_reg == {3'b000, cfg.stopBitSelect}) state_next = ST_IDLE;
         end
         ST_BREAK: if (bitTick) begin
            txLine_next = 1'b0;
            cnt_next    = cnt_reg + 4'h1;
            if (cnt_reg == `BREAK_ZEROS) begin
               txLine_next    = 1'b1;
               breakDone_next = 1'b1;
               state_next     = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         shift_reg <= 9'h000;
         cnt_reg   <= 4'h0;
         par_reg   <= 1'b0;
         txLine    <= 1'b1;
         breakDone <= 1'b0;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         cnt_reg   <= cnt_next;
         par_reg   <= par_next;
         txLine    <= txLine_next;
         breakDone <= breakDone_next;
      end
   end

   assign busy = (state_reg != ST_IDLE);

   AST_START_LOW: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == ST_START && bitTick) |=> (!txLine && state_reg == ST_DATA))
      else $error("start bit not low");
   AST_STOP_HIGH: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == ST_STOP && bitTick) |=> txLine)
      else $error("stop bit not high");
   AST_PARITY_VAL: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == ST_IDLE && load && !breakReq && cfg.parityDataSelect == 2'b01)
      |=> (par_reg == ^loadData[7:0]))
      else $error("even parity wrong");
   AST_NINE_BITS: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == ST_DATA && bitTick && cnt_reg == 4'h8) |=> state_reg == ST_STOP)
      else $error("nine bit frame did not go to stop");
   AST_TWO_STOPS: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == ST_STOP && bitTick && cnt_reg == 4'h0 && cfg.stopBitSelect) |=> state_reg == ST_STOP)
      else $error("second stop bit missing");
endmodule : uart_tx_shifter

// ### dv/uart_line_rx.sv
// remote serial receiver model: decodes frames seen on the transmit pin
// assumes the bench sets format and bit period while the line is idle
`timescale 1ns/1ps
module uart_line_rx (
   input  wire logic        mclk,
   input  wire logic        pin,
   input  wire logic        inv,
   input  wire logic [7:0]  per,
   input  wire logic [3:0]  nData,
   input  wire logic        hasPar,
   input  wire logic [1:0]  nStop,
   output logic             rxValid,
   output logic [11:0]      rxWord
);
   logic line;

   assign line = pin ^ inv;

   ////////////////////////////////////////////////////////////////////////////
   // start found, then sampling at mid bit; short glitches are rejected
   initial begin
      rxValid = 1'b0;
      rxWord  = 12'h800;
      wait (line === 1'b1);
      forever begin
         do @(posedge mclk); while (line !== 1'b0);
         repeat (per / 2) @(posedge mclk);
         if (line === 1'b0) begin
            rxWord <= 12'h800;
            for (int i = 0; i < nData; i++) begin
               repeat (per) @(posedge mclk);
               rxWord[i] <= line;
            end
            if (hasPar) begin
               repeat (per) @(posedge mclk);
               rxWord[9] <= line;
            end
            for (int i = 0; i < nStop; i++) begin
               repeat (per) @(posedge mclk);
               rxWord[10 + i] <= line;
            end
            rxValid <= 1'b1;
            @(posedge mclk);
            rxValid <= 1'b0;
            while (line !== 1'b1) @(posedge mclk);
         end
      end
   end
endmodule : uart_line_rx

// ### dv/uart_frame_format_and_status_tb.sv
// bench for the serial frame format and status block
// assumes zero wait apb answers and the line model on the transmit pin
`timescale 1ns/1ps
`include "uart_cfg.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module uart_frame_format_and_status_tb
   import uart_pkg::*;
;
   logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, serialTxPin, irq;
   logic [11:0] paddr, rxWord, f;
   logic [31:0] pwdata, prdata, rdData, r;
   logic [3:0]  pstrb, nData;
   logic        inv, hasPar, rxValid, irqExp;
   logic [1:0]  fmt, nStop;
   logic [7:0]  per;
   logic [34:0] apbQ[$];
   logic [11:0] frmQ[$];
   int          miscompares, checked, seed, n;

   uart_frame_format_and_status uart_frame_format_and_status_i (.mclk(mclk), .resetn(resetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serialTxPin(serialTxPin), .irq(irq));
   uart_line_rx uart_line_rx_i (.mclk(mclk), .pin(serialTxPin), .inv(inv), .per(per), .nData(nData),
      .hasPar(hasPar), .nStop(nStop), .rxValid(rxValid), .rxWord(rxWord));

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rdData = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   // kind 0 ignores the answer, 1 expects an error, 2 checks the data
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] k = 2'h2);
      apbQ.push_back({k, irqExp, e});
      xfer(1'b0, a, 32'h0000_0000);
   endtask : rd

   task automatic setup(input logic ir, input logic [1:0] fm, input logic h, input logic s, input logic [1:0] dv);
      fmt    = fm;
      per    = (dv + 8'h01) * (h ? 8'h04 : 8'h10);
      nData  = (fm == 2'b11) ? 4'h9 : 4'h8;
      hasPar = (fm == 2'b01) || (fm == 2'b10);
      nStop  = s ? 2'h2 : 2'h1;
      wr(`OFF_BAUD, {30'h0, dv});
      wr(`OFF_MODE, {19'h0, ir, 8'h0, h, fm, s});
   endtask : setup

   task automatic send(input logic [8:0] d);
      logic p;
      p = (^d[7:0]) ^ (fmt == 2'b10);
      frmQ.push_back({2'b11, hasPar & p, (fmt == 2'b11) ? d : {1'b0, d[7:0]}});
      wr(`OFF_DATA, {23'h0, d});
   endtask : send

   task automatic drain;
      while (frmQ.size() != 0) @(posedge mclk);
      repeat (2 * per) @(posedge mclk);
   endtask : drain

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      logic [34:0] e;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = apbQ.pop_front();
         if (e[34:33] != 2'h0) begin
            `CHK("apb error", e[34:33] == 2'h1, pslverr)
            `CHK("irq", e[32], irq)
         end
         if (e[34:33] == 2'h2) `CHK("read data", e[31:0], prdata)
      end
      if (rxValid === 1'b1) begin
         f = frmQ.pop_front();
         `CHK("frame", f, rxWord)
      end
   end

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   initial begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      stop_test();
   end

   initial begin
      seed = 34004;
      {resetn, psel, penable, pwrite, inv, irqExp, hasPar, fmt} = '0;
      {paddr, pwdata} = '0;
      pstrb = 4'hF;
      {per, nData, nStop} = {8'h10, 4'h8, 2'h1};
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      rd(`OFF_MODE, 32'h0000_0000);
      rd(`OFF_STAT, 32'h0000_0100);
      rd(`OFF_BAUD, 32'h0000_0000);
      rd(`OFF_IRQ_STAT, 32'h0000_0000);
      rd(`OFF_IRQ_MASK, 32'h0000_0000);
      rd(12'h020, 32'h0000_0000, 2'h1);
      wr(`OFF_MODE, 32'h0000_FFFF);
      rd(`OFF_MODE, 32'h0000_100F);
      wr(`OFF_STAT, 32'h0000_0300);
      rd(`OFF_STAT, 32'h0000_0100);
      for (int c = 0; c < 8; c++) begin
         r = $random(seed);
         setup(1'b0, c[1:0], c[2], c[0] ^ c[2], r[5:4] % 2'h3);
         send(r[8:0]);
         repeat (2 * per) @(posedge mclk);
         send(r[24:16]);
         // refused: a byte is already pending
         wr(`OFF_DATA, 32'h0000_01FF);
         rd(`OFF_STAT, 32'h0000_0200);
         drain();
      end
      rd(`OFF_IRQ_STAT, 32'h0000_0001);
      wr(`OFF_IRQ_MASK, 32'h0000_0003);
      irqExp = 1'b1;
      rd(`OFF_IRQ_MASK, 32'h0000_0003);
      wr(`OFF_IRQ_STAT, 32'h0000_0001);
      irqExp = 1'b0;
      rd(`OFF_IRQ_STAT, 32'h0000_0000);
      setup(1'b0, 2'b00, 1'b1, 1'b0, 2'h0);
      frmQ.push_back(12'h800);
      wr(`OFF_STAT, 32'h0000_0800);
      n = 0;
      do begin
         rd(`OFF_STAT, 32'h0000_0000, 2'h0);
         n++;
      end while (rdData[11] !== 1'b0 && n < 100);
      `CHK("break cleared", 1'b0, rdData[11])
      drain();
      irqExp = 1'b1;
      // the break also counts as a finished transmission
      rd(`OFF_IRQ_STAT, 32'h0000_0003);
      rd(`OFF_STAT, 32'h0000_0100);
      wr(`OFF_IRQ_STAT, 32'h0000_0003);
      irqExp = 1'b0;
      setup(1'b0, 2'b00, 1'b0, 1'b0, 2'h0);
      wr(`OFF_STAT, 32'h0000_4000);
      rd(`OFF_STAT, 32'h0000_4100);
      send(9'h0A5);
      drain();
      wr(`OFF_MODE, 32'h0000_1000);
      inv <= 1'b1;
      repeat (per) @(posedge mclk);
      send(9'h13C);
      drain();
      `CHK("idle level", 1'b0, serialTxPin)
      stop_test();
   end
endmodule : uart_frame_format_and_status_tb
